/* File: fax_status_pkg.sv */
package fax_status_pkg;
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_MASK = 12'h004;
  localparam logic [11:0] ADDR_BYTES = 12'h008;
  localparam logic [11:0] ADDR_CTRL = 12'h00c;
  localparam int BIT_WHITE = 0;
  localparam int BIT_TYPE_LO = 1;
  localparam int BIT_FAULT = 4;
  localparam int BIT_SEP = 5;
  localparam int BIT_TAG = 6;
  localparam int BIT_EOL = 7;
  localparam int BIT_REF_RDY = 8;
  localparam int BIT_RAW_RD_RDY = 9;
  localparam int BIT_RAW_WR_RDY = 10;
  localparam int BIT_TC_FAULT = 11;
  localparam logic [15:0] MASK_IRQ_BITS = 16'h0390;
  localparam logic [15:0] MASK_WRITABLE = 16'h1f90;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [9:0] BYTES_RESET = 10'h000;
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_DECODE = 2;
  typedef enum logic [1:0] {MODE_MH, MODE_MR, MODE_MMR, MODE_SPARE} coding_mode_t;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_RTC = 3'h1;
  localparam logic [2:0] ERR_TERM = 3'h2;
  localparam logic [2:0] ERR_SHORT = 3'h4;
  localparam logic [2:0] ERR_LONG = 3'h5;
  localparam logic [2:0] ERR_CODE = 3'h6;
endpackage : fax_status_pkg

/* File: fax_codec_line_status.sv */
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fax_codec_line_status #(
  parameter int BYTE_W = 10
) (
  // System.
  input wire logic clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // FIFO levels.
  input wire logic raw_fifo_full,
  input wire logic raw_fifo_has_data,
  input wire logic ref_fifo_full,
  // Coder events.
  input wire logic line_start,
  input wire logic code_line_done,
  input wire logic code_last_written,
  // Decoder events.
  input wire logic dec_eol_code,
  input wire logic dec_tag_bit,
  input wire logic dec_tag_value,
  input wire logic dec_separated_eol,
  input wire logic dec_byte,
  input wire logic dec_black_pixel,
  input wire logic dec_out_drained,
  input wire logic dec_fill_between_eol,
  input wire logic dec_missing_term,
  input wire logic dec_bad_codeword,
  input wire logic dec_data_valid,
  // Results.
  output logic dec_data_write,
  output logic [1:0] coding_mode,
  output logic decode_mode,
  output logic [9:0] line_byte_count,
  output logic irq
);
  import fax_status_pkg::*;

  logic [15:0] mask_q;
  logic [9:0] bytes_q;
  logic [2:0] ctrl_q;
  logic eol_q;
  logic tag_q;
  logic sep_q;
  logic fault_q;
  logic tc_q;
  logic white_q;
  logic seen_black_q;
  logic [2:0] etype_q;
  logic [BYTE_W-1:0] cnt_q;
  logic pend_q;
  logic tag_wait_q;

  wire apb_access = psel && penable;
  wire apb_wr = apb_access && pwrite;
  wire sel_status = paddr == ADDR_STATUS;
  wire sel_mask = paddr == ADDR_MASK;
  wire sel_bytes = paddr == ADDR_BYTES;
  wire sel_ctrl = paddr == ADDR_CTRL;
  wire mapped = sel_status || sel_mask || sel_bytes || sel_ctrl;
  wire decoding = ctrl_q[CTRL_DECODE];
  wire [1:0] mode = ctrl_q[CTRL_MODE_LO +: 2];
  wire is_mmr = mode == MODE_MMR;
  wire two_d = (mode == MODE_MR) || is_mmr;

  // Flags held as levels from the FIFO state, not latched.
  wire raw_wr_rdy = !decoding && !raw_fifo_full;
  wire ref_rdy = two_d && !ref_fifo_full;
  wire raw_rd_rdy = decoding && raw_fifo_has_data;

  wire [BYTE_W-1:0] bytes_ext = BYTE_W'(bytes_q);
  wire count_hit = dec_byte && (cnt_q + BYTE_W'(1) == bytes_ext);
  wire count_over = dec_byte && (cnt_q >= bytes_ext) && !is_mmr;

  // Error detection; the first error in a line fixes the type.
  logic [2:0] err_code;
  always_comb begin
    err_code = ERR_NONE;
    if (dec_bad_codeword) begin
      err_code = ERR_CODE;
    end else if (count_over) begin
      err_code = ERR_LONG;
    end else if (dec_eol_code && (cnt_q < bytes_ext)) begin
      err_code = ERR_SHORT;
    end else if (dec_missing_term) begin
      err_code = ERR_TERM;
    end else if (dec_fill_between_eol) begin
      err_code = ERR_RTC;
    end
  end
  wire err_now = decoding && !eol_q && (err_code != ERR_NONE);

  // Line completion: MH at the EOL code, MR after its tag, MMR by count.
  wire mh_done = (mode == MODE_MH) && dec_eol_code;
  wire mr_done = (mode == MODE_MR) && tag_wait_q && dec_tag_bit;
  wire mmr_done = is_mmr && count_hit;
  wire dec_done = decoding && (mh_done || mr_done || mmr_done);
  // The flag waits for the line buffer writes to drain.
  wire dec_eol = decoding && (pend_q || dec_done) && dec_out_drained;
  wire code_eol = !decoding && code_line_done && code_last_written;

  // Decoded data past an error never reaches the line buffer.
  assign dec_data_write = dec_data_valid && decoding && !fault_q && !err_now;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_q <= MASK_RESET;
      bytes_q <= BYTES_RESET;
      ctrl_q <= 3'h0;
    end else if (apb_wr) begin
      if (sel_mask) begin
        mask_q <= pwdata[15:0] & MASK_WRITABLE;
      end
      if (sel_bytes) begin
        bytes_q <= pwdata[9:0];
      end
      if (sel_ctrl) begin
        ctrl_q <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || line_start) begin
      // New line wipes the per-line bits 0 to 7 and bit 11.
      eol_q <= 1'b0;
      tag_q <= 1'b0;
      sep_q <= 1'b0;
      fault_q <= 1'b0;
      etype_q <= ERR_NONE;
      white_q <= 1'b0;
      tc_q <= 1'b0;
      cnt_q <= '0;
      pend_q <= 1'b0;
      tag_wait_q <= 1'b0;
    end else begin
      if (dec_byte) begin
        cnt_q <= cnt_q + BYTE_W'(1);
      end
      if (err_now && !fault_q) begin
        fault_q <= 1'b1;
        etype_q <= err_code;
        tc_q <= err_code == ERR_TERM;
      end
      if (dec_eol_code && mode == MODE_MR) begin
        tag_wait_q <= 1'b1;
      end
      if (dec_tag_bit && tag_wait_q) begin
        tag_q <= dec_tag_value;
      end
      if (dec_separated_eol) begin
        sep_q <= 1'b1;
      end
      if (dec_done && !dec_out_drained) begin
        pend_q <= 1'b1;
      end
      if (dec_eol || code_eol) begin
        eol_q <= 1'b1;
        pend_q <= 1'b0;
        // All white holds only if no black pixel came and no fault hid data.
        white_q <= decoding && !seen_black_q && !fault_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || line_start) begin
      seen_black_q <= 1'b0;
    end else if (dec_black_pixel && decoding) begin
      seen_black_q <= 1'b1;
    end
  end

  // Tag and separated flags read as zero unless end-of-line is set.
  wire [15:0] status = {4'h0, tc_q, raw_wr_rdy, raw_rd_rdy, ref_rdy, eol_q,
                        tag_q && eol_q, sep_q && eol_q, fault_q, etype_q, white_q};

  assign irq = |(status & mask_q & MASK_IRQ_BITS);

  wire [31:0] rd_mux = sel_status ? {16'h0000, status} :
                       sel_mask ? {16'h0000, mask_q} :
                       sel_bytes ? {22'h0, bytes_q} :
                       sel_ctrl ? {29'h0, ctrl_q} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = apb_access && !mapped;
  assign coding_mode = mode;
  assign decode_mode = decoding;
  assign line_byte_count = bytes_q;

  // The checks below watch what this block drives and take its inputs as legal.
  // A mode change in the same cycle as a line end is judged by the mode of the cycle before.
  AST_RAW_RDY: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!decoding && raw_fifo_full) |-> !status[BIT_RAW_WR_RDY]
  ) else $error("raw ready while full");

  AST_RAW_RDY_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!decoding && !raw_fifo_full) |-> status[BIT_RAW_WR_RDY]
  ) else $error("raw ready missing");

  AST_RAW_RDY_DEC: assert property (
    @(posedge clk) disable iff (!reset_n)
    decoding |-> !status[BIT_RAW_WR_RDY]
  ) else $error("raw write ready while decoding");

  AST_REF_RDY: assert property (
    @(posedge clk) disable iff (!reset_n)
    status[BIT_REF_RDY] == (two_d && !ref_fifo_full)
  ) else $error("ref ready wrong");

  AST_REF_RDY_1D: assert property (
    @(posedge clk) disable iff (!reset_n)
    (mode == MODE_MH) |-> !status[BIT_REF_RDY]
  ) else $error("ref ready in one-dimensional mode");

  AST_CODE_EOL: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!$past(decoding) && $rose(eol_q)) |-> $past(code_line_done && code_last_written)
  ) else $error("early code eol");

  AST_CODE_EOL_WHITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    ($rose(eol_q) && !$past(decoding)) |-> !white_q
  ) else $error("all white while coding");

  AST_DEC_EOL: assert property (
    @(posedge clk) disable iff (!reset_n)
    ($past(decoding) && $rose(eol_q)) |-> $past(dec_out_drained)
  ) else $error("eol before drain");

  AST_DEC_EOL_DONE: assert property (
    @(posedge clk) disable iff (!reset_n)
    ($past(decoding) && $rose(eol_q)) |-> $past(pend_q || dec_done)
  ) else $error("eol before line decoded");

  AST_MH_COMPLETE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (decoding && mode == MODE_MH && dec_eol_code && dec_out_drained && !line_start) |=> eol_q
  ) else $error("mh line not completed");

  AST_MR_NEEDS_TAG: assert property (
    @(posedge clk) disable iff (!reset_n)
    (decoding && mode == MODE_MR && !tag_wait_q && !pend_q && !eol_q && !line_start) |=> !eol_q
  ) else $error("mr line ended without tag");

  AST_MMR_COMPLETE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (decoding && is_mmr && count_hit && dec_out_drained && !line_start) |=> eol_q
  ) else $error("mmr line not completed");

  AST_TAG_GATE: assert property (
    @(posedge clk) disable iff (!reset_n)
    !eol_q |-> !status[BIT_TAG] && !status[BIT_SEP]
  ) else $error("tag without eol");

  AST_TAG_SHOWN: assert property (
    @(posedge clk) disable iff (!reset_n)
    eol_q |-> status[BIT_TAG] == tag_q
  ) else $error("tag hidden at eol");

  AST_SEP_SHOWN: assert property (
    @(posedge clk) disable iff (!reset_n)
    eol_q |-> status[BIT_SEP] == sep_q
  ) else $error("separated flag hidden at eol");

  AST_FAULT_DEC: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!decoding && !fault_q && !line_start) |=> !fault_q
  ) else $error("fault while coding");

  AST_FAULT_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    (err_now && !line_start) |=> fault_q
  ) else $error("fault not raised");

  AST_SUPPRESS: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_q |-> !dec_data_write
  ) else $error("write after fault");

  AST_SUPPRESS_NOW: assert property (
    @(posedge clk) disable iff (!reset_n)
    err_now |-> !dec_data_write
  ) else $error("write in error cycle");

  AST_FAULT_HOLDS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (fault_q && !line_start) |=> fault_q
  ) else $error("fault dropped within line");

  AST_TYPE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (etype_q != 3'h3) && (etype_q != 3'h7) && (fault_q || etype_q == ERR_NONE)
  ) else $error("bad type");

  AST_TYPE_HOLDS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (fault_q && !line_start) |=> $stable(etype_q)
  ) else $error("type changed within line");

  AST_TYPE_RTC: assert property (
    @(posedge clk) disable iff (!reset_n)
    (err_now && !fault_q && !line_start && dec_fill_between_eol && !dec_bad_codeword &&
     !count_over && !dec_missing_term && !dec_eol_code) |=> etype_q == ERR_RTC
  ) else $error("fill type wrong");

  AST_TYPE_TERM: assert property (
    @(posedge clk) disable iff (!reset_n)
    (err_now && !fault_q && !line_start && dec_missing_term && !dec_bad_codeword &&
     !count_over && !dec_eol_code) |=> etype_q == ERR_TERM && tc_q
  ) else $error("terminating type wrong");

  AST_TC: assert property (
    @(posedge clk) disable iff (!reset_n)
    tc_q |-> fault_q && etype_q == ERR_TERM
  ) else $error("tc mismatch");

  AST_TYPE_SHORT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (decoding && !eol_q && !fault_q && !line_start && dec_eol_code && (cnt_q < bytes_ext) &&
     !dec_bad_codeword && !count_over) |=> etype_q == ERR_SHORT
  ) else $error("short type wrong");

  AST_TYPE_LONG: assert property (
    @(posedge clk) disable iff (!reset_n)
    (decoding && !eol_q && !fault_q && !line_start && count_over && !dec_bad_codeword) |=>
     etype_q == ERR_LONG
  ) else $error("long type wrong");

  AST_TYPE_CODE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (decoding && !eol_q && !fault_q && !line_start && dec_bad_codeword) |=>
     fault_q && etype_q == ERR_CODE
  ) else $error("codeword type wrong");

  AST_WHITE_EOL: assert property (
    @(posedge clk) disable iff (!reset_n)
    white_q |-> eol_q
  ) else $error("all white without eol");

  AST_WHITE_CAUSE: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(white_q) |-> $past(!seen_black_q && !fault_q)
  ) else $error("all white after black or fault");

  AST_WHITE_CLEAR: assert property (
    @(posedge clk) disable iff (!reset_n)
    line_start |=> !white_q
  ) else $error("all white kept on new line");

  AST_CLEAR: assert property (
    @(posedge clk) disable iff (!reset_n)
    line_start |=> status[7:0] == 8'h00
  ) else $error("line start not cleared");

  AST_IRQ: assert property (
    @(posedge clk) disable iff (!reset_n)
    (eol_q && mask_q[BIT_EOL]) |-> irq
  ) else $error("missed irq");

  AST_IRQ_FAULT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (fault_q && mask_q[BIT_FAULT]) |-> irq
  ) else $error("missed fault irq");

  AST_IRQ_QUIET: assert property (
    @(posedge clk) disable iff (!reset_n)
    (mask_q == MASK_RESET) |-> !irq
  ) else $error("irq while masked");

  AST_NO_ERR_CODE: assert property (
    @(posedge clk) disable iff (!reset_n)
    !fault_q |-> etype_q == ERR_NONE
  ) else $error("type without fault");
endmodule : fax_codec_line_status
`default_nettype wire

/* File: fax_codec_line_status_test.sv */
`timescale 1ns/100ps
`default_nettype none
module fax_codec_line_status_test;
  import fax_status_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Event pulses and level inputs, packed; the pulse task drives ev and lv is set directly.
  logic [8:0] ev = 9'h000;
  logic [7:0] lv = 8'h00;
  logic dec_data_write;
  logic [1:0] coding_mode;
  logic decode_mode;
  logic [9:0] line_byte_count;
  logic irq;
  logic [31:0] rd_q;
  logic err_q;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  fax_codec_line_status u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raw_fifo_full(lv[5]), .raw_fifo_has_data(lv[6]), .ref_fifo_full(lv[7]),
    .line_start(ev[0]), .code_line_done(lv[0]), .code_last_written(lv[1]),
    .dec_eol_code(ev[1]), .dec_tag_bit(ev[2]), .dec_tag_value(lv[4]),
    .dec_separated_eol(ev[3]), .dec_byte(ev[4]), .dec_black_pixel(ev[5]),
    .dec_out_drained(lv[2]), .dec_fill_between_eol(ev[6]), .dec_missing_term(ev[7]),
    .dec_bad_codeword(ev[8]), .dec_data_valid(lv[3]), .dec_data_write(dec_data_write),
    .coding_mode(coding_mode), .decode_mode(decode_mode), .line_byte_count(line_byte_count),
    .irq(irq));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic give_verdict;
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input string n, input logic [11:0] a, input logic [15:0] m,
    input logic [15:0] e);
    apb(1'b0, a, 32'h0);
    check(n, rd_q & {16'h0, m}, {16'h0, e});
  endtask : rd
  task automatic pulse(input logic [8:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 9'h000;
  endtask : pulse
  // The line buffer is held busy first, so the end of line must wait for it.
  task automatic dline(input string n, input logic [8:0] p, input logic [8:0] f,
    input logic [15:0] e, input logic w);
    pulse(9'h001);
    @(posedge clk) lv <= 8'h18;
    pulse(p);
    pulse(p);
    @(negedge clk);
    check(n, {31'h0, dec_data_write}, {31'h0, w});
    pulse(f);
    rd(n, ADDR_STATUS, 16'h0080, 16'h0000);
    @(posedge clk) lv <= 8'h1c;
    rd(n, ADDR_STATUS, 16'h08ff, e);
    $display("test %s done", n);
  endtask : dline
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd("status", ADDR_STATUS, 16'hffff, 16'h0400);
    rd("mask", ADDR_MASK, 16'hffff, MASK_RESET);
    rd("bytes", ADDR_BYTES, 16'hffff, {6'h0, BYTES_RESET});
    apb(1'b1, ADDR_MASK, 32'hffff);
    rd("mask_wr", ADDR_MASK, 16'hffff, MASK_WRITABLE);
    apb(1'b1, ADDR_MASK, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'hffff);
    rd("status_ro", ADDR_STATUS, 16'hffff, 16'h0400);
    apb(1'b1, 12'h010, 32'h1);
    check("slverr", {31'h0, err_q}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", rd_q, 32'h0);
    $display("test registers done");
    apb(1'b1, ADDR_CTRL, 32'h1);
    @(negedge clk);
    check("mode", {29'h0, decode_mode, coding_mode}, 32'h1);
    rd("ref_rdy", ADDR_STATUS, 16'hffff, 16'h0500);
    @(posedge clk) lv <= 8'ha0;
    rd("full", ADDR_STATUS, 16'h0700, 16'h0000);
    @(posedge clk) lv <= 8'h01;
    rd("not_written", ADDR_STATUS, 16'h0080, 16'h0000);
    @(posedge clk) lv <= 8'h03;
    rd("code_eol", ADDR_STATUS, 16'h0080, 16'h0080);
    @(posedge clk) lv <= 8'h00;
    apb(1'b1, ADDR_MASK, 32'h0080);
    @(negedge clk);
    check("irq_on", {31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_MASK, 32'h0010);
    @(negedge clk);
    check("irq_off", {31'h0, irq}, 32'h0);
    pulse(9'h001);
    rd("new_line", ADDR_STATUS, 16'h00ff, 16'h0000);
    $display("test coding done");
    apb(1'b1, ADDR_CTRL, 32'h4);
    dline("mh_white", 9'h000, 9'h002, 16'h0081, 1'b1);
    dline("mh_black", 9'h020, 9'h002, 16'h0080, 1'b1);
    dline("mh_sep", 9'h008, 9'h002, 16'h00a1, 1'b1);
    dline("fill", 9'h040, 9'h002, 16'h0092, 1'b0);
    dline("term", 9'h080, 9'h002, 16'h0894, 1'b0);
    dline("code", 9'h100, 9'h002, 16'h009c, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h5);
    dline("mr_tag", 9'h002, 9'h004, 16'h00c1, 1'b1);
    apb(1'b1, ADDR_BYTES, 32'h3);
    @(negedge clk);
    check("bytes_out", {22'h0, line_byte_count}, 32'h3);
    apb(1'b1, ADDR_CTRL, 32'h6);
    dline("mmr", 9'h010, 9'h010, 16'h0081, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h4);
    dline("short", 9'h010, 9'h002, 16'h0098, 1'b1);
    apb(1'b1, ADDR_BYTES, 32'h1);
    dline("long", 9'h010, 9'h002, 16'h009a, 1'b0);
    pulse(9'h001);
    rd("cleared", ADDR_STATUS, 16'h00ff, 16'h0000);
    give_verdict();
  end
endmodule : fax_codec_line_status_test
`default_nettype wire
